//--- verilog/adc_display_control.v
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "adc_display_consts.vh"
module adc_display_control #(
  parameter INT_LOW_CLOCKS = `INT_LOW_CLOCKS,
  parameter INT_HIGH_CLOCKS = `INT_HIGH_CLOCKS,
  parameter DE_MAX_CLOCKS = `DE_MAX_CLOCKS,
  parameter REST_CLOCKS = `REST_CLOCKS,
  parameter GAIN_CLOCKS = `GAIN_CLOCKS,
  parameter SLOT_CLOCKS = `SLOT_CLOCKS
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // analog front end
  input wire range_in,
  input wire zero_cross,
  input wire input_negative,
  input wire short_circuit_icon_below,
  input wire weak_supply,
  output wire [3:0] phase_code,
  output wire inputs_shorted,
  // shared flag pins
  input wire over_flag_in,
  output reg over_flag_out,
  output wire over_flag_oe,
  input wire low_count_flag_in,
  output reg low_count_flag_out,
  output wire low_count_flag_oe,
  // freeze pin
  input wire hold_in,
  input wire hold_float,
  output wire hold_out,
  output wire hold_oe,
  // continuity pin
  input wire short_circuit_icon_in,
  output reg short_circuit_icon_out,
  output wire short_circuit_icon_oe,
  // decimal point inputs
  input wire decimal_point_one,
  input wire decimal_point_two,
  // display
  output reg backplane_one,
  output reg backplane_two,
  output reg backplane_three,
  output reg [11:0] seg_r,
  output reg annunciator_drive
);

  // ---------------------------------------------------------------
  // phases
  // ---------------------------------------------------------------
  localparam [3:0] S_INT = 4'h0;
  localparam [3:0] S_DE1 = 4'h1;
  localparam [3:0] S_REST1 = 4'h2;
  localparam [3:0] S_GAIN1 = 4'h3;
  localparam [3:0] S_DE2 = 4'h4;
  localparam [3:0] S_REST2 = 4'h5;
  localparam [3:0] S_GAIN2 = 4'h6;
  localparam [3:0] S_DE3 = 4'h7;
  localparam [3:0] S_DONE = 4'h8;
  localparam [31:0] INT_LOW = INT_LOW_CLOCKS - 1;
  localparam [31:0] INT_HIGH = INT_HIGH_CLOCKS - 1;
  localparam [31:0] DE_MAX = DE_MAX_CLOCKS - 1;
  localparam [31:0] REST_LAST = REST_CLOCKS - 1;
  localparam [31:0] GAIN_LAST = GAIN_CLOCKS - 1;
  localparam [31:0] SLOT_LAST = SLOT_CLOCKS - 1;

  reg div_r;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [14:0] cnt_r;
  reg pass_r;
  reg range_r;
  reg neg_r;
  reg signed [23:0] fine_r;
  reg signed [23:0] in_fine_r;
  reg signed [23:0] latch_r;
  reg run_r;
  reg update_r;
  reg [1:0] slot_r;
  reg [14:0] slot_cnt_r;
  reg pol_r;

  wire tick;
  wire phase_end;
  wire signed [23:0] reading;
  wire signed [23:0] corrected;
  wire signed [23:0] live;
  wire signed [23:0] shown;
  wire [23:0] latch_mag;
  wire [23:0] shown_mag;
  wire [16:0] mag;
  wire write_en;
  wire read_en;

  // ---------------------------------------------------------------
  // conversion clock
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 1'b0;
    end else begin
      div_r <= ~div_r;
    end
  end
  assign tick = div_r;

  // ---------------------------------------------------------------
  // measurement sequencer
  // ---------------------------------------------------------------
  assign phase_code = state_r;
  assign inputs_shorted = pass_r;
  assign reading = neg_r ? -fine_r : fine_r;
  assign corrected = in_fine_r - reading;

  assign phase_end = (state_r == S_INT) ?
                     (cnt_r == (range_r ? INT_HIGH[14:0] : INT_LOW[14:0])) :
                     (state_r == S_REST1 || state_r == S_REST2) ? (cnt_r == REST_LAST[14:0]) :
                     (state_r == S_GAIN1 || state_r == S_GAIN2) ? (cnt_r == GAIN_LAST[14:0]) :
                     (zero_cross || cnt_r == DE_MAX[14:0]);

  always @* begin
    case (state_r)
      S_INT: state_nxt = S_DE1;
      S_DE1: state_nxt = S_REST1;
      S_REST1: state_nxt = S_GAIN1;
      S_GAIN1: state_nxt = S_DE2;
      S_DE2: state_nxt = S_REST2;
      S_REST2: state_nxt = S_GAIN2;
      S_GAIN2: state_nxt = S_DE3;
      S_DE3: state_nxt = S_DONE;
      default: state_nxt = S_INT;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_DONE;
      cnt_r <= 15'h0000;
      pass_r <= 1'b0;
      range_r <= 1'b0;
      neg_r <= 1'b0;
      fine_r <= 24'sh000000;
      in_fine_r <= 24'sh000000;
      latch_r <= 24'sh000000;
      update_r <= 1'b0;
    end else begin
      update_r <= 1'b0;
      if (tick) begin
        if (state_r == S_DONE) begin
          cnt_r <= 15'h0000;
          if (pass_r) begin
            pass_r <= 1'b0;
            if (hold_float || !hold_in) begin
              latch_r <= corrected / 24'sh000064;
              update_r <= 1'b1;
            end
          end else begin
            in_fine_r <= reading;
            pass_r <= 1'b1;
          end
          if (run_r || !pass_r) begin
            state_r <= S_INT;
            fine_r <= 24'sh000000;
            range_r <= range_in;
          end
        end else if (phase_end) begin
          state_r <= state_nxt;
          cnt_r <= 15'h0000;
          if (state_r == S_INT) begin
            neg_r <= input_negative;
          end
        end else begin
          cnt_r <= cnt_r + 15'h0001;
          case (state_r)
            S_DE1: fine_r <= fine_r + `STEP_COARSE;
            S_DE2: fine_r <= fine_r - `STEP_MID;
            S_DE3: fine_r <= fine_r + `STEP_FINE;
            default: fine_r <= fine_r;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // flags and shared pins
  // ---------------------------------------------------------------
  assign latch_mag = latch_r[23] ? -latch_r : latch_r;
  assign live = (neg_r ? -fine_r : fine_r) / 24'sh000064;
  assign shown = (!hold_float && !hold_in) ? live : latch_r;
  assign shown_mag = shown[23] ? -shown : shown;
  assign mag = (shown_mag > 24'h01FFFF) ? 17'h1FFFF : shown_mag[16:0];
  assign over_flag_oe = 1'b1;
  assign low_count_flag_oe = 1'b1;
  assign short_circuit_icon_oe = 1'b1;
  assign hold_oe = 1'b1;
  assign hold_out = ~update_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_flag_out <= 1'b0;
      low_count_flag_out <= 1'b0;
      short_circuit_icon_out <= 1'b0;
    end else begin
      over_flag_out <= (latch_mag > {7'h00, `OVER_LIMIT});
      low_count_flag_out <= (latch_mag < {7'h00, `LOW_LIMIT});
      short_circuit_icon_out <= short_circuit_icon_below;
    end
  end

  // ---------------------------------------------------------------
  // digit decode
  // ---------------------------------------------------------------
  function [6:0] seg7;
    input [3:0] d;
    begin
      case (d) // bits g f e d c b a
        4'h0: seg7 = 7'h3F;
        4'h1: seg7 = 7'h06;
        4'h2: seg7 = 7'h5B;
        4'h3: seg7 = 7'h4F;
        4'h4: seg7 = 7'h66;
        4'h5: seg7 = 7'h6D;
        4'h6: seg7 = 7'h7D;
        4'h7: seg7 = 7'h07;
        4'h8: seg7 = 7'h7F;
        4'h9: seg7 = 7'h6F;
        default: seg7 = 7'h00;
      endcase
    end
  endfunction

  wire [16:0] units_v = mag % 17'h0000A;
  wire [16:0] tens_v = (mag / 17'h0000A) % 17'h0000A;
  wire [16:0] hundreds_v = (mag / 17'h00064) % 17'h0000A;
  wire [16:0] thousands_v = (mag / 17'h003E8) % 17'h0000A;
  wire [6:0] dg1 = seg7(units_v[3:0]);
  wire [6:0] dg2 = seg7(tens_v[3:0]);
  wire [6:0] dg3 = seg7(hundreds_v[3:0]);
  wire [6:0] dg4 = seg7(thousands_v[3:0]);
  wire lead_one = (mag >= 17'h02710);
  wire minus = shown[23];

  // per pin: bit0 for first backplane, bit1 second, bit2 third
  wire [35:0] map;
  assign map[2:0] = {short_circuit_icon_in, dg1[2], dg1[1]};
  assign map[5:3] = {dg1[3], dg1[6], dg1[0]};
  assign map[8:6] = {decimal_point_one, dg1[4], dg1[5]};
  assign map[11:9] = {weak_supply, dg2[2], dg2[1]};
  assign map[14:12] = {dg2[3], dg2[6], dg2[0]};
  assign map[17:15] = {decimal_point_two, dg2[4], dg2[5]};
  assign map[20:18] = {minus, dg3[2], dg3[1]};
  assign map[23:21] = {dg3[3], dg3[6], dg3[0]};
  assign map[26:24] = {low_count_flag_in, dg3[4], dg3[5]};
  assign map[29:27] = {lead_one, dg4[2], dg4[1]};
  assign map[32:30] = {dg4[6], dg4[3], dg4[0]};
  assign map[35:33] = {over_flag_in, dg4[4], dg4[5]};

  // ---------------------------------------------------------------
  // backplane multiplexer
  // ---------------------------------------------------------------
  reg [11:0] lit;
  integer i;
  always @* begin
    lit = 12'h000;
    for (i = 0; i < 12; i = i + 1) begin
      lit[i] = map[i * 3 + slot_r];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_r <= 2'h0;
      slot_cnt_r <= 15'h0000;
      pol_r <= 1'b0;
      backplane_one <= 1'b0;
      backplane_two <= 1'b0;
      backplane_three <= 1'b0;
      seg_r <= 12'h000;
      annunciator_drive <= 1'b0;
    end else begin
      if (tick) begin
        if (slot_cnt_r == SLOT_LAST[14:0]) begin
          slot_cnt_r <= 15'h0000;
          if (slot_r == 2'h2) begin
            slot_r <= 2'h0;
            pol_r <= ~pol_r;
          end else begin
            slot_r <= slot_r + 2'h1;
          end
        end else begin
          slot_cnt_r <= slot_cnt_r + 15'h0001;
        end
      end
      backplane_one <= (slot_r == 2'h0) ? pol_r : ~pol_r;
      backplane_two <= (slot_r == 2'h1) ? pol_r : ~pol_r;
      backplane_three <= (slot_r == 2'h2) ? pol_r : ~pol_r;
      seg_r <= pol_r ? ~lit : lit;
      annunciator_drive <= pol_r;
    end
  end

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  assign pready = 1'b1;
  assign write_en = psel && penable && pwrite;
  assign read_en = psel && !pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= `CTRL_RESET;
    end else if (write_en && paddr[7:0] == `OFS_CTRL) begin
      run_r <= pwdata[`CTRL_RUN_BIT];
    end
  end

  always @* begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    if (read_en || write_en) begin
      case (paddr[7:0])
        `OFS_CTRL: prdata = {31'h00000000, run_r};
        `OFS_STATUS: prdata = {22'h000000, update_r, pass_r, state_r,
                               short_circuit_icon_out, range_r, low_count_flag_out, over_flag_out};
        `OFS_RESULT: prdata = {{8{latch_r[23]}}, latch_r};
        default: pslverr = penable;
      endcase
    end
  end

endmodule // adc_display_control

//--- verilog/adc_display_consts.vh
`ifndef ADC_DISPLAY_CONSTS_VH
`define ADC_DISPLAY_CONSTS_VH
// ---------------------------------------------------------------
// register offsets and fields
// ---------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_RESULT 8'h08
`define CTRL_RUN_BIT 0
`define CTRL_RESET 1'b1
// ---------------------------------------------------------------
// timing counts in conversion clocks
// ---------------------------------------------------------------
`define OSC_DIVIDE 2
`define INT_LOW_CLOCKS 10000
`define INT_HIGH_CLOCKS 1000
`define DE_MAX_CLOCKS 25000
`define REST_CLOCKS 16
`define GAIN_CLOCKS 16
`define SLOT_CLOCKS 64
// ---------------------------------------------------------------
// count thresholds and ramp weights
// ---------------------------------------------------------------
`define OVER_LIMIT 17'h04E1F
`define LOW_LIMIT 17'h003E8
`define STEP_COARSE 24'h000064
`define STEP_MID 24'h00000A
`define STEP_FINE 24'h000001
`endif

//--- tb/adc_display_control_asserts.sv
`timescale 1ns/1ns
module adc_ctl_chk #(
  parameter INT_LOW_CLOCKS = 20,
  parameter INT_HIGH_CLOCKS = 4,
  parameter SLOT_CLOCKS = 2
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire [31:0] paddr,
  input wire pslverr,
  // converter and pins
  input wire range_in,
  input wire [3:0] phase_code,
  input wire inputs_shorted,
  input wire over_flag_out,
  input wire low_count_flag_out,
  input wire short_circuit_icon_below,
  input wire short_circuit_icon_out,
  input wire hold_in,
  input wire hold_float,
  input wire hold_out,
  // display and icon inputs
  input wire short_circuit_icon_in,
  input wire weak_supply,
  input wire over_flag_in,
  input wire low_count_flag_in,
  input wire decimal_point_one,
  input wire decimal_point_two,
  input wire backplane_one,
  input wire backplane_two,
  input wire backplane_three,
  input wire [11:0] seg_r,
  input wire annunciator_drive
);
  reg [15:0] int_cnt_r;
  reg rng_r;
  reg [15:0] ann_cnt_r;
  reg ann_q_r;
  reg ann_seen_r;
  wire slot_three = backplane_three == annunciator_drive;
  // ----
  // integrate length counter
  // ----
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_cnt_r <= 16'h0000;
      rng_r <= 1'b0;
    end else begin
      int_cnt_r <= (phase_code == 4'h0) ? int_cnt_r + 16'h0001 : 16'h0000;
      if (phase_code != 4'h0) rng_r <= range_in;
    end
  end
  // ----
  // backplane half period counter
  // ----
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ann_q_r <= 1'b0;
      ann_cnt_r <= 16'h0000;
      ann_seen_r <= 1'b0;
    end else begin
      ann_q_r <= annunciator_drive;
      if (annunciator_drive != ann_q_r) begin
        ann_cnt_r <= 16'h0001;
        ann_seen_r <= 1'b1;
      end else begin
        ann_cnt_r <= ann_cnt_r + 16'h0001;
      end
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_int_length: assert property ($fell(phase_code == 4'h0) |->
    int_cnt_r == (rng_r ? 2 * INT_HIGH_CLOCKS : 2 * INT_LOW_CLOCKS)) else $error("bad integrate");
  a_phase_order: assert property (phase_code != $past(phase_code) |->
    phase_code == $past(phase_code) + 4'h1 || (phase_code == 4'h0 && $past(phase_code) == 4'h8))
    else $error("bad phase step");
  a_shorted_start: assert property ($rose(inputs_shorted) |-> phase_code == 4'h0)
    else $error("bad offset start");
  a_short_circuit_icon_follow: assert property ($past(presetn) |-> short_circuit_icon_out == $past(short_circuit_icon_below))
    else $error("bad short_circuit_icon out");
  a_hold_pulse: assert property ($fell(hold_out) |=> hold_out) else $error("long pulse");
  a_hold_freeze: assert property ((!hold_float && hold_in) [*2] |-> hold_out)
    else $error("update under hold");
  a_flags_excl: assert property (!(over_flag_out && low_count_flag_out))
    else $error("both flags");
  a_apb_err: assert property (psel && penable |->
    pslverr == !(paddr[7:0] inside {8'h00, 8'h04, 8'h08})) else $error("bad slverr");
  a_bp_select: assert property ($past(presetn) |->
    $countones({backplane_one == annunciator_drive, backplane_two == annunciator_drive,
    backplane_three == annunciator_drive}) == 1) else $error("bad backplanes");
  a_icon_pins: assert property ($past(presetn) && slot_three |->
    ({seg_r[11], seg_r[8], seg_r[5], seg_r[3], seg_r[2], seg_r[0]} ^ {6{annunciator_drive}}) ==
    $past({over_flag_in, low_count_flag_in, decimal_point_two, weak_supply,
    decimal_point_one, short_circuit_icon_in})) else $error("bad icon segment");
  a_bp_period: assert property (ann_seen_r && annunciator_drive != ann_q_r |->
    ann_cnt_r == 6 * SLOT_CLOCKS) else $error("bad backplane period");
  c_pulse: cover property ($fell(hold_out));
  c_over: cover property ($rose(over_flag_out));
  c_high: cover property (range_in && phase_code == 4'h0);
endmodule // adc_ctl_chk

//--- tb/front_end_model.sv
`timescale 1ns/1ns
module front_end_model #(
  parameter BASE = 3
) (
  // clock
  input wire pclk,
  // converter state
  input wire [3:0] phase_code,
  input wire inputs_shorted,
  input wire [15:0] extra,
  // comparator
  output reg zero_cross
);
  reg [16:0] n_r;
  reg [16:0] lim_nxt;
  wire de = phase_code == 4'h1 || phase_code == 4'h4 || phase_code == 4'h7;
  // ----
  // comparator trips after a set ramp time
  // ----
  always @* begin
    lim_nxt = 17'(2 * BASE);
    if (phase_code == 4'h1 && !inputs_shorted) lim_nxt = lim_nxt + {extra, 1'b0};
  end
  initial zero_cross = 1'b0;
  always @(posedge pclk) begin
    n_r <= de ? n_r + 17'h00001 : 17'h00000;
    zero_cross <= de && n_r >= lim_nxt;
  end
endmodule // front_end_model

//--- tb/test_multimeter_adc_display_control.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module test_multimeter_adc_display_control;
  logic pclk, presetn, psel, penable, pwrite, range_in, input_negative, hold_in, hold_float;
  logic short_circuit_icon_below, short_circuit_icon_in, weak_supply, over_flag_in, low_count_flag_in, chk_fl;
  logic decimal_point_one, decimal_point_two;
  logic [31:0] paddr, pwdata, e_rd, last_res;
  logic [15:0] extra;
  logic [1:0] e_fl;
  wire [31:0] prdata;
  wire [3:0] phase_code;
  wire pready, pslverr, zero_cross, inputs_shorted, over_flag_out, low_count_flag_out;
  wire hold_out, short_circuit_icon_out;
  int err_total, n_tests;
  logic [31:0] rd_q[$];
  logic [1:0] fl_q[$];
  int ks[6] = '{5, 999, 1000, 12, 1, 20000};
  adc_display_control #(.INT_LOW_CLOCKS(20), .INT_HIGH_CLOCKS(4), .REST_CLOCKS(2),
    .GAIN_CLOCKS(2), .SLOT_CLOCKS(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .range_in(range_in), .zero_cross(zero_cross),
    .input_negative(input_negative), .short_circuit_icon_below(short_circuit_icon_below), .weak_supply(weak_supply),
    .phase_code(phase_code), .inputs_shorted(inputs_shorted), .over_flag_in(over_flag_in),
    .over_flag_out(over_flag_out), .over_flag_oe(), .low_count_flag_in(low_count_flag_in),
    .low_count_flag_out(low_count_flag_out), .low_count_flag_oe(), .hold_in(hold_in),
    .hold_float(hold_float), .hold_out(hold_out), .hold_oe(), .short_circuit_icon_in(short_circuit_icon_in),
    .short_circuit_icon_out(short_circuit_icon_out), .short_circuit_icon_oe(), .decimal_point_one(decimal_point_one),
    .decimal_point_two(decimal_point_two), .backplane_one(), .backplane_two(),
    .backplane_three(), .seg_r(), .annunciator_drive());
  front_end_model fe (.pclk(pclk), .phase_code(phase_code), .inputs_shorted(inputs_shorted),
    .extra(extra), .zero_cross(zero_cross));
  // ----
  // clock, random pins, monitor
  // ----
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    {short_circuit_icon_below, short_circuit_icon_in, weak_supply, over_flag_in} <= 4'($urandom);
    {low_count_flag_in, decimal_point_one, decimal_point_two} <= 3'($urandom);
  end
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
      e_rd = rd_q.pop_front();
      `CHK("prdata", e_rd, prdata)
    end
    if (chk_fl) begin
      e_fl = fl_q.pop_front();
      `CHK("flags", e_fl, {over_flag_out, low_count_flag_out})
    end
    chk_fl = !hold_out && fl_q.size() > 0;
  end
  // ----
  // tasks
  // ----
  task automatic print_verdict();
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
    input logic [31:0] e);
    int i;
    i = 0;
    if (!wr) rd_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      err_total++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_ev(input logic sel);
    int i;
    logic prev;
    prev = 1'b1;
    for (i = 0; i < 50000; i++) begin
      @(posedge pclk);
      if (sel ? !hold_out : (inputs_shorted && !prev)) break;
      prev = inputs_shorted;
    end
    if (i == 50000) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic conv(input int k, input logic sc, input logic lv);
    logic ng;
    ng = 1'($urandom);
    wait_ev(1'b0);
    extra <= k[15:0];
    range_in <= sc;
    input_negative <= ng;
    hold_in <= 1'b0;
    hold_float <= lv;
    wait_ev(1'b1);
    @(posedge pclk);
    fl_q.push_back({k > 19999, k < 1000});
    wait_ev(1'b1);
    last_res = ng ? -k : k;
    apb(1'b0, 32'h00000008, 32'h00000000, last_res);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    {presetn, psel, penable, pwrite, range_in, input_negative, hold_in} = 7'h00;
    {short_circuit_icon_below, short_circuit_icon_in, weak_supply, over_flag_in} = 4'h0;
    {low_count_flag_in, decimal_point_one, decimal_point_two} = 3'h0;
    hold_float = 1'b1;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    extra = 16'h0000;
    err_total = 0;
    n_tests = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(42));
    apb(1'b0, 32'h00000000, 32'h00000000, 32'h00000001);
    apb(1'b1, 32'h00000000, 32'h00000000, 32'h00000000);
    apb(1'b0, 32'h00000000, 32'h00000000, 32'h00000000);
    apb(1'b1, 32'h00000000, 32'h00000001, 32'h00000000);
    apb(1'b0, 32'h0000000C, 32'h00000000, 32'h00000000);
    foreach (ks[j]) begin
      conv(ks[j], 1'(j), j != 3);
      if (j == 1) begin
        wait_ev(1'b0);
        hold_float <= 1'b0;
        hold_in <= 1'b1;
        extra <= 16'h0028;
        wait_ev(1'b0);
        wait_ev(1'b0);
        apb(1'b1, 32'h00000008, 32'h00001234, 32'h00000000);
        apb(1'b0, 32'h00000008, 32'h00000000, last_res);
        hold_float <= 1'b1;
      end
    end
    print_verdict();
  end
endmodule // test_multimeter_adc_display_control
bind adc_display_control adc_ctl_chk #(.INT_LOW_CLOCKS(INT_LOW_CLOCKS),
  .INT_HIGH_CLOCKS(INT_HIGH_CLOCKS), .SLOT_CLOCKS(SLOT_CLOCKS)) chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .range_in(range_in), .phase_code(phase_code), .inputs_shorted(inputs_shorted),
  .over_flag_out(over_flag_out), .low_count_flag_out(low_count_flag_out),
  .short_circuit_icon_below(short_circuit_icon_below), .short_circuit_icon_out(short_circuit_icon_out), .hold_in(hold_in), .hold_float(hold_float),
  .hold_out(hold_out), .short_circuit_icon_in(short_circuit_icon_in), .weak_supply(weak_supply),
  .over_flag_in(over_flag_in), .low_count_flag_in(low_count_flag_in),
  .decimal_point_one(decimal_point_one), .decimal_point_two(decimal_point_two),
  .backplane_one(backplane_one), .backplane_two(backplane_two),
  .backplane_three(backplane_three), .seg_r(seg_r), .annunciator_drive(annunciator_drive));
